// File: design/wwf_flash_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wwf_flash_if;
  wwf_pkg::wwf_flmode_t mode;
  logic lamp_a;
  logic lamp_b;
  modport gen (input mode, output lamp_a, output lamp_b);
  modport use_side (output mode, input lamp_a, input lamp_b);
endinterface : wwf_flash_if
`default_nettype wire

// File: design/wwf_flasher.sv
`timescale 1ns/1ps
`default_nettype none
module wwf_flasher (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode and lamps
  wwf_flash_if.gen fl
);
  logic [wwf_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
  logic a_ff, nxt_a;
  logic b_ff, nxt_b;
  logic [wwf_pkg::TMR_W-1:0] slot;
  logic [wwf_pkg::TMR_W-1:0] pos;
  logic [2:0] idx;

  always_comb begin
    slot = wwf_pkg::TMR_W'(wwf_pkg::FLASH_ON_CYC + wwf_pkg::FLASH_OFF_CYC);
    nxt_tmr = tmr_ff + wwf_pkg::TMR_W'(1);
    if (tmr_ff == wwf_pkg::TMR_W'(wwf_pkg::BURST_CYC - 1)) begin
      nxt_tmr = '0;
    end
    if (fl.mode == wwf_pkg::FL_OFF) begin
      nxt_tmr = '0;
    end
    // Lamp A bursts from 0, lamp B after A's burst, never overlapping
    pos = tmr_ff;
    idx = 3'h0;
    nxt_a = 1'b0;
    nxt_b = 1'b0;
    if (tmr_ff < wwf_pkg::TMR_W'(3 * (wwf_pkg::FLASH_ON_CYC +
        wwf_pkg::FLASH_OFF_CYC))) begin
      idx = 3'(tmr_ff / slot);
      pos = tmr_ff - wwf_pkg::TMR_W'(idx) * slot;
      nxt_a = (pos < wwf_pkg::TMR_W'(wwf_pkg::FLASH_ON_CYC));
    end else if (tmr_ff < wwf_pkg::TMR_W'(6 * (wwf_pkg::FLASH_ON_CYC +
        wwf_pkg::FLASH_OFF_CYC))) begin
      pos = tmr_ff - wwf_pkg::TMR_W'(3 * (wwf_pkg::FLASH_ON_CYC +
        wwf_pkg::FLASH_OFF_CYC));
      idx = 3'(pos / slot);
      pos = pos - wwf_pkg::TMR_W'(idx) * slot;
      nxt_b = (pos < wwf_pkg::TMR_W'(wwf_pkg::FLASH_ON_CYC)) &&
              (fl.mode == wwf_pkg::FL_DOUBLE);
    end
    if (fl.mode == wwf_pkg::FL_OFF) begin
      nxt_a = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_ff <= '0;
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end else begin
      tmr_ff <= nxt_tmr;
      a_ff <= nxt_a;
      b_ff <= nxt_b;
    end
  end

  assign fl.lamp_a = a_ff;
  assign fl.lamp_b = b_ff;
endmodule : wwf_flasher
`default_nettype wire

// File: design/wwf_pkg.sv
package wwf_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 10000000;
  // Flash timing
  localparam int unsigned FLASH_ON_MS = 40;
  localparam int unsigned FLASH_OFF_MS = 40;
  localparam int unsigned BURST_PERIOD_MS = 1200;
  localparam int unsigned WIGWAG_HALF_MS = 500;
  localparam int unsigned FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam int unsigned FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;
  localparam int unsigned BURST_CYC = CLK_HZ / 1000 * BURST_PERIOD_MS;
  localparam int unsigned WIGWAG_HALF_CYC = CLK_HZ / 1000 * WIGWAG_HALF_MS;
  localparam int unsigned FLASHES_PER_BURST = 3;
  localparam int unsigned TMR_W = 24;
  localparam int unsigned NUM_BRK = 8;
  // Programming profile and switch codes
  localparam logic [4:0] PROG_PROFILE = 5'h1F;
  localparam logic [2:0] SEL_WW_ON = 3'h2;
  localparam logic [2:0] SEL_WW_OFF = 3'h3;
  localparam logic [2:0] SEL_FL_OFF = 3'h4;
  localparam logic [2:0] SEL_FL_SINGLE = 3'h5;
  localparam logic [2:0] SEL_FL_DOUBLE = 3'h6;
  // Breaker bit positions
  localparam int unsigned BRK1 = 0;
  localparam int unsigned BRK2 = 1;
  localparam int unsigned BRK3 = 2;
  localparam int unsigned BRK4 = 3;
  localparam int unsigned BRK5 = 4;
  localparam int unsigned BRK6 = 5;
  // Register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_EXT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FL_OFF = 2'b00,
    FL_SINGLE = 2'b01,
    FL_DOUBLE = 2'b10
  } wwf_flmode_t;
endpackage : wwf_pkg

// File: design/wwf_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Wigwag on breakers 1 and 2, or joined pairs 1+2 and 3+4.
// - Wigwag enabled only by programming profile 32; else normal operation.
// - Grounded control input requests its breaker on.
// - Each off-then-on switch cycle toggles steady-on and alternating flashing.
// - Wigwag switch inputs off keep both landing-light sets off.
// - While switch on, external controller gives on/off and mode commands.
// - Flasher on breaker 5 (single) or breakers 5 and 6 (double).
// - Three flashes per burst, one burst every 1.2 seconds.
// - Each flash on 40 ms, off 40 ms between flashes.
// - Double flasher breakers never on together.
// - Flasher mode set only by programming profile 32, then kept.
module wwf_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Panel switch inputs, low when grounded
  input wire logic [7:0] sw_n,
  // Dipswitches and profile pairing
  input wire logic [7:0] dip,
  input wire logic pair_34,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Breaker commands
  output logic [7:0] brk_on,
  // Programming mode indicator
  output logic prog_active
);
  // Input synchronisers, three stages
  logic [7:0] s1_ff, s2_ff, s3_ff, nxt_s1, nxt_s2, nxt_s3;
  logic [7:0] sw_on_ff, nxt_sw_on;
  always_comb begin
    nxt_s1 = ~sw_n;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_sw_on = sw_on_ff;
    for (int i = 0; i < 8; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_sw_on[i] = s3_ff[i];
      end
    end
  end

  // Dipswitches pass three stages and are read once after reset
  logic cap_ff, nxt_cap;
  logic prog_ff, nxt_prog;
  logic ww_en_ff, nxt_ww_en;
  wwf_pkg::wwf_flmode_t flm_ff, nxt_flm;
  logic [7:0] d1_ff, d2_ff, d3_ff;
  logic [2:0] dv_ff;
  logic dip_ok;
  always_comb begin
    // Chain must refill after reset before its stages can be trusted
    dip_ok = !cap_ff && dv_ff[2] && (d2_ff == d3_ff);
    nxt_cap = cap_ff | dip_ok;
    nxt_prog = prog_ff;
    nxt_ww_en = ww_en_ff;
    nxt_flm = flm_ff;
    if (dip_ok && d3_ff[7:3] == wwf_pkg::PROG_PROFILE) begin
      nxt_prog = 1'b1;
      case (d3_ff[2:0])
        wwf_pkg::SEL_WW_ON: nxt_ww_en = 1'b1;
        wwf_pkg::SEL_WW_OFF: nxt_ww_en = 1'b0;
        wwf_pkg::SEL_FL_OFF: nxt_flm = wwf_pkg::FL_OFF;
        wwf_pkg::SEL_FL_SINGLE: nxt_flm = wwf_pkg::FL_SINGLE;
        wwf_pkg::SEL_FL_DOUBLE: nxt_flm = wwf_pkg::FL_DOUBLE;
        default: nxt_prog = 1'b1;
      endcase
    end
  end

  // Wigwag state
  logic ww_mode_ff, nxt_ww_mode;
  logic ww_prev_ff, nxt_ww_prev;
  logic ww_ph_ff, nxt_ww_ph;
  logic [wwf_pkg::TMR_W-1:0] ww_tmr_ff, nxt_ww_tmr;
  logic ext_on_ff, nxt_ext_on;
  logic ext_mode_ff, nxt_ext_mode;
  logic ww_sw;
  logic ext_wr;
  logic [31:0] wdat;
  always_comb begin
    ww_sw = sw_on_ff[wwf_pkg::BRK1] & sw_on_ff[wwf_pkg::BRK2];
    if (pair_34) begin
      ww_sw = ww_sw & sw_on_ff[wwf_pkg::BRK3] & sw_on_ff[wwf_pkg::BRK4];
    end
    nxt_ww_prev = ww_sw;
    nxt_ww_mode = ww_mode_ff;
    nxt_ext_on = ext_on_ff;
    nxt_ext_mode = ext_mode_ff;
    if (ww_sw && !ww_prev_ff) begin
      nxt_ww_mode = ~ww_mode_ff;
      nxt_ext_on = 1'b1;
      nxt_ext_mode = 1'b0;
    end
    if (ext_wr && ww_sw) begin
      nxt_ext_on = wdat[0];
      nxt_ext_mode = wdat[1];
    end
    nxt_ww_tmr = ww_tmr_ff + wwf_pkg::TMR_W'(1);
    nxt_ww_ph = ww_ph_ff;
    if (ww_tmr_ff == wwf_pkg::TMR_W'(wwf_pkg::WIGWAG_HALF_CYC - 1)) begin
      nxt_ww_tmr = '0;
      nxt_ww_ph = ~ww_ph_ff;
    end
  end

  // Flasher
  wwf_flash_if fl ();
  assign fl.mode = flm_ff;
  wwf_flasher u_flasher (
    .clk(clk),
    .rst(rst),
    .fl(fl)
  );

  // Breaker outputs
  logic [7:0] nxt_brk;
  logic ww_alt;
  logic set_a, set_b;
  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    // Next-state values, so no stale mode or output shows for a cycle
    nxt_brk = nxt_prog ? 8'h00 : sw_on_ff;
    ww_alt = nxt_ww_mode ^ nxt_ext_mode;
    if (ww_en_ff && !nxt_prog) begin
      if (!ww_sw || !nxt_ext_on) begin
        set_a = 1'b0;
        set_b = 1'b0;
      end else if (ww_alt) begin
        set_a = ww_ph_ff;
        set_b = ~ww_ph_ff;
      end else begin
        set_a = 1'b1;
        set_b = 1'b1;
      end
      if (pair_34) begin
        // Joined 1+2 is one wing set, joined 3+4 the other
        nxt_brk[wwf_pkg::BRK1] = set_a;
        nxt_brk[wwf_pkg::BRK2] = set_a;
        nxt_brk[wwf_pkg::BRK3] = set_b;
        nxt_brk[wwf_pkg::BRK4] = set_b;
      end else begin
        nxt_brk[wwf_pkg::BRK1] = set_a;
        nxt_brk[wwf_pkg::BRK2] = set_b;
      end
    end
    if (!nxt_prog && flm_ff != wwf_pkg::FL_OFF) begin
      nxt_brk[wwf_pkg::BRK5] = sw_on_ff[wwf_pkg::BRK5] & fl.lamp_a;
      if (flm_ff == wwf_pkg::FL_DOUBLE) begin
        nxt_brk[wwf_pkg::BRK6] = sw_on_ff[wwf_pkg::BRK6] & fl.lamp_b;
      end
    end
  end

  // AXI4-Lite slave, single outstanding write and read
  logic awr_ff, wr_ff, arr_ff;
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic [1:0] br_ff, nxt_br;
  logic rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0] rr_ff, nxt_rr;
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    ext_wr = 1'b0;
    wdat = wd_ff;
    if (s_axi_awvalid && awr_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
    end
    if (aw_ff && w_ff) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = wwf_pkg::RESP_SLVERR;
      if (awa_ff == wwf_pkg::REG_EXT) begin
        nxt_br = wwf_pkg::RESP_OKAY;
        ext_wr = 1'b1;
      end
    end
    if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_arvalid && arr_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = wwf_pkg::RESP_OKAY;
      case (s_axi_araddr)
        wwf_pkg::REG_CFG: nxt_rd = {27'h0, flm_ff, ww_en_ff, prog_ff, 1'b0};
        wwf_pkg::REG_EXT: nxt_rd = {30'h0, ext_mode_ff, ext_on_ff};
        wwf_pkg::REG_STAT: nxt_rd = {21'h0, ww_ph_ff, ww_mode_ff, ww_sw,
                                     brk_on};
        default: begin
          nxt_rd = 32'h0;
          nxt_rr = wwf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
      sw_on_ff <= 8'h00;
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
      d3_ff <= 8'h00;
      cap_ff <= 1'b0;
      prog_ff <= 1'b0;
      dv_ff <= 3'h0;
      ww_mode_ff <= 1'b1;
      ww_prev_ff <= 1'b0;
      ww_ph_ff <= 1'b0;
      ww_tmr_ff <= '0;
      ext_on_ff <= 1'b1;
      ext_mode_ff <= 1'b0;
      brk_on <= 8'h00;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0;
      bv_ff <= 1'b0;
      br_ff <= wwf_pkg::RESP_OKAY;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      rr_ff <= wwf_pkg::RESP_OKAY;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      sw_on_ff <= nxt_sw_on;
      d1_ff <= dip;
      d2_ff <= d1_ff;
      d3_ff <= d2_ff;
      cap_ff <= nxt_cap;
      prog_ff <= nxt_prog;
      dv_ff <= {dv_ff[1:0], 1'b1};
      ww_mode_ff <= nxt_ww_mode;
      ww_prev_ff <= nxt_ww_prev;
      ww_ph_ff <= nxt_ww_ph;
      ww_tmr_ff <= nxt_ww_tmr;
      ext_on_ff <= nxt_ext_on;
      ext_mode_ff <= nxt_ext_mode;
      brk_on <= nxt_brk;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end

  // Selection survives reset, standing in for non-volatile storage;
  // limitation: undefined until the device is first programmed
  always_ff @(posedge clk) begin
    ww_en_ff <= nxt_ww_en;
    flm_ff <= nxt_flm;
  end

  // Ready flags drop while their capture flag or, for writes, the response is pending
  always_ff @(posedge clk) begin
    if (rst) begin
      awr_ff <= 1'b0;
      wr_ff <= 1'b0;
      arr_ff <= 1'b0;
    end else begin
      awr_ff <= !nxt_aw && !nxt_bv;
      wr_ff <= !nxt_w && !nxt_bv;
      arr_ff <= !nxt_rv;
    end
  end
  assign s_axi_awready = awr_ff;
  assign s_axi_wready = wr_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
  assign prog_active = prog_ff;
endmodule : wwf_sequencer
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, pair_34, prog_active;
  logic [7:0] want_on, sw_n, dip, brk_on, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fails, check_count, cycles;
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  wwf_panel panel (.clk(clk), .want_on(want_on), .sw_n(sw_n));
  wwf_sequencer uut (.*);
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axr
  // Bounded poll: switch path goes through a synchroniser
  task automatic wait_brk(input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    while ((brk_on & m) !== e && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk({24'h0, brk_on & m}, {24'h0, e});
  endtask : wait_brk
  // Power cycle; selection must survive it
  task automatic power(input logic [7:0] v, input logic p);
    @(posedge clk);
    dip <= v;
    pair_34 <= p;
    want_on <= 8'h00;
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : power
  task automatic prog_mode(input logic [2:0] sel);
    power({5'h1F, sel}, 1'h0);
    want_on <= 8'hFF;
    repeat (12) @(posedge clk);
    chk({23'h0, prog_active, brk_on}, 32'h100);
  endtask : prog_mode
  task automatic t_normal;
    power(8'h00, 1'h0);
    want_on <= 8'h84;
    wait_brk(8'hFF, 8'h84);
    axr(wwf_pkg::REG_CFG);
    chk(d & 32'h1E, 32'h0);
    axr(8'hFC);
    chk({d[29:0], r}, {30'h0, wwf_pkg::RESP_SLVERR});
    axw(wwf_pkg::REG_CFG, 32'h1E);
    chk({30'h0, r}, {30'h0, wwf_pkg::RESP_SLVERR});
    want_on <= 8'h00;
    wait_brk(8'hFF, 8'h00);
    $display("normal operation test done");
  endtask : t_normal
  task automatic t_wigwag(input logic p);
    logic [7:0] m, e;
    m = p ? 8'h0F : 8'h03;
    prog_mode(wwf_pkg::SEL_WW_ON);
    power(8'h00, p);
    axr(wwf_pkg::REG_CFG);
    chk(d & 32'h4, 32'h4);
    wait_brk(m, 8'h00);
    want_on <= m;
    wait_brk(m, m);
    want_on <= 8'h00;
    wait_brk(m, 8'h00);
    want_on <= m;
    repeat (12) @(posedge clk);
    e = p ? (brk_on[0] ? 8'h03 : 8'h0C) : (brk_on[0] ? 8'h01 : 8'h02);
    chk({24'h0, brk_on & m}, {24'h0, e});
    axr(wwf_pkg::REG_STAT);
    chk(d & 32'h200, 32'h200);
    axw(wwf_pkg::REG_EXT, 32'h3);
    wait_brk(m, m);
    axw(wwf_pkg::REG_EXT, 32'h0);
    wait_brk(m, 8'h00);
    want_on <= 8'h00;
    $display("alternating lights test done");
  endtask : t_wigwag
  task automatic t_flash;
    for (int i = 0; i < 3; i++) begin
      prog_mode(wwf_pkg::SEL_FL_OFF + 3'(i));
      power(8'h00, 1'h0);
      axr(wwf_pkg::REG_CFG);
      chk(d & 32'h18, {27'h0, 2'(i), 3'h0});
      want_on <= 8'h30;
      repeat (20) @(posedge clk);
      if (i == 0) chk({30'h0, brk_on[5:4]}, 32'h3);
      else if (i == 1) chk({30'h0, brk_on[5:4]}, 32'h3);
      else chk({30'h0, brk_on[5:4]}, 32'h1);
      want_on <= 8'h00;
      wait_brk(8'h30, 8'h00);
    end
    $display("flasher test done");
  endtask : t_flash
  initial begin
    rst = 1'h1;
    dip = 8'h00;
    pair_34 = 1'h0;
    want_on = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    // Selection is kept through reset, so give it a known start
    prog_mode(wwf_pkg::SEL_WW_OFF);
    prog_mode(wwf_pkg::SEL_FL_OFF);
    t_normal();
    t_wigwag(1'h0);
    t_wigwag(1'h1);
    t_flash();
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// File: dv/wwf_panel.sv
`timescale 1ns/1ps
`default_nettype none
module wwf_panel (
  // Clock
  input wire logic clk,
  // Pilot's switch positions
  input wire logic [7:0] want_on,
  // Switch contacts, pulled up when open
  output logic [7:0] sw_n
);
  always_ff @(posedge clk) begin
    sw_n <= ~want_on;
  end
endmodule : wwf_panel
`default_nettype wire

// File: dv/wwf_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wwf_seq_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Switches and breakers
  input wire logic [7:0] sw_n,
  input wire logic [7:0] brk_on,
  input wire logic prog_active,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Flasher mode as last reported by a configuration read
  logic [7:0] ar_ff;
  logic dbl_ff;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_ff <= s_axi_araddr;
    end
    if (rst || prog_active) begin
      dbl_ff <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready &&
        ar_ff == wwf_pkg::REG_CFG) begin
      dbl_ff <= (s_axi_rdata[4:3] == wwf_pkg::FL_DOUBLE);
    end
  end
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Long enough for the input synchroniser to settle
  sequence all_off;
    (sw_n == 8'hFF) [*8];
  endsequence
  chk_prog_holds_off:
    assert property (prog_active |-> brk_on == 8'h00)
    else $error("breaker on while programming");
  chk_flash_apart:
    assert property (dbl_ff |->
      !(brk_on[wwf_pkg::BRK5] && brk_on[wwf_pkg::BRK6]))
    else $error("both flasher breakers on");
  chk_switch_off:
    assert property (all_off |=> brk_on == 8'h00)
    else $error("breaker on with all switches off");
  chk_release_quiet:
    assert property ($fell(rst) |-> brk_on == 8'h00 && !s_axi_bvalid)
    else $error("outputs active after reset");
  chk_write_answer:
    assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer:
    assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  chk_b_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_unmapped:
    assert property (rd_taken ##0 (s_axi_araddr > wwf_pkg::REG_STAT) |=>
      s_axi_rresp == wwf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : wwf_seq_properties
bind wwf_sequencer wwf_seq_properties u_props (.clk, .rst, .sw_n, .brk_on,
  .prog_active, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire
